// ===== rsb_boot_ctrl.sv
// reset strap capture and boot path selection
//
// Overview of operation
// - straps captured once when power-on reset releases, then held.
// - code 00 host boot PLL off, 01 I2C boot, 11 reserved.
// - code 10 host boot with PLL enabled.
// - strobe polarity strap 0 active low, 1 active high.
// - width strap 0 gives 16-bit host port, 1 gives 8-bit.
// - PLL bypassed after power-on reset until software or a code 10 host boot enables it.
// - after power-on reset run internal boot ROM loader on bypassed clock first.
// - host boot uses no DMA and polled handshakes on both sides.
// - strobe style set by style strap with polarity, captured at release.
// - host straps only sampled at power-on release; hard reset keeps them.
// - host word bit 0 is the least significant bit.
// - I2C boot switches shared pins to their I2C function.
// - during I2C boot the device is bus master.
`timescale 1ns/1ps
`include "rsb_map.svh"
module rsb_boot_ctrl
   import rsb_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        POWER_ON_RESET_N,
   input  wire logic        HARD_RESET_N,
   input  wire logic [1:0]  BOOT_SOURCE_STRAP,
   input  wire logic        WATCHDOG_ENABLE_STRAP,
   input  wire logic        HOST_STROBE_POLARITY_STRAP,
   input  wire logic        HOST_STROBE_STYLE_STRAP,
   input  wire logic        HOST_BYTE_WIDTH_STRAP,
   input  wire logic        SW_PLL_ENABLE,
   input  wire logic        HOST_WORD_VALID,
   input  wire logic [15:0] HOST_WORD,
   output logic             WATCHDOG_ENABLE,
   output logic             HOST_STROBE_ACTIVE_HIGH,
   output logic             HOST_STROBE_STYLE,
   output logic             HOST_WIDTH_8BIT,
   output logic             PLL_ENABLE,
   output logic             PLL_BYPASS,
   output logic             ROM_BOOT_ACTIVE,
   output logic             HOST_BOOT_ACTIVE,
   output logic             HOST_DMA_ENABLE,
   output logic             HOST_IRQ_ENABLE,
   output logic [63:0]      HOST_GROUP,
   output logic             HOST_GROUP_VALID,
   output logic             I2C_PIN_SELECT,
   output logic             I2C_MASTER_MODE,
   output logic             BOOT_RESERVED
);
   import rsb_pkg::*;

   // =====================================================
   // strap capture
   logic [1:0] boot_reg;
   logic       wdog_reg;
   logic       pol_reg;
   logic       style_reg;
   logic       width_reg;
   logic       capture;
   logic       in_reset;
   assign in_reset = ~POWER_ON_RESET_N | ~HARD_RESET_N;

   rsb_strap_latch u_latch
   (
      .CLK       (CLK),
      .RST       (RST),
      .por_active(~POWER_ON_RESET_N),
      .boot_in   (BOOT_SOURCE_STRAP),
      .wdog_in   (WATCHDOG_ENABLE_STRAP),
      .pol_in    (HOST_STROBE_POLARITY_STRAP),
      .style_in  (HOST_STROBE_STYLE_STRAP),
      .width_in  (HOST_BYTE_WIDTH_STRAP),
      .boot_reg  (boot_reg),
      .wdog_reg  (wdog_reg),
      .pol_reg   (pol_reg),
      .style_reg (style_reg),
      .width_reg (width_reg),
      .capture   (capture)
   );

   assign WATCHDOG_ENABLE         = wdog_reg;
   assign HOST_STROBE_ACTIVE_HIGH = pol_reg;
   assign HOST_STROBE_STYLE       = style_reg;
   assign HOST_WIDTH_8BIT         = width_reg;

   // =====================================================
   // boot source decode
   function automatic rsb_src_t decode_src(input logic [1:0] code);
      case (code)
         `RSB_BOOT_HOST_NOPLL: decode_src = RSB_SRC_HOST;
         `RSB_BOOT_HOST_PLL:   decode_src = RSB_SRC_HOST;
         `RSB_BOOT_I2C:        decode_src = RSB_SRC_I2C;
         default:              decode_src = RSB_SRC_NONE;
      endcase
   endfunction : decode_src

   rsb_src_t src;
   assign src           = decode_src(boot_reg);
   assign BOOT_RESERVED = (src == RSB_SRC_NONE);

   // =====================================================
   // boot sequence
   rsb_state_t state_reg;
   rsb_state_t state_next;
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         RSB_ST_RESET: if (!in_reset) state_next = RSB_ST_ROM;
         RSB_ST_ROM:
         begin
            case (decode_src(boot_reg))
               RSB_SRC_HOST: state_next = RSB_ST_HOST;
               RSB_SRC_I2C:  state_next = RSB_ST_I2C;
               default:      state_next = RSB_ST_HALT;
            endcase
         end
         RSB_ST_HOST: ;
         RSB_ST_I2C:  ;
         RSB_ST_HALT: ;
         default:     state_next = RSB_ST_RESET;
      endcase
      if (in_reset)
         state_next = RSB_ST_RESET;
   end
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         state_reg <= RSB_ST_RESET;
      else
         state_reg <= state_next;

   assign ROM_BOOT_ACTIVE  = (state_reg == RSB_ST_ROM);
   assign HOST_BOOT_ACTIVE = (state_reg == RSB_ST_HOST);
   // polled, non-DMA host transfers throughout host boot
   assign HOST_DMA_ENABLE  = 1'b0;
   assign HOST_IRQ_ENABLE  = 1'b0;
   assign I2C_PIN_SELECT   = (state_reg == RSB_ST_I2C);
   assign I2C_MASTER_MODE  = (state_reg == RSB_ST_I2C);

   // =====================================================
   // pll control
   // power-on reset forces bypass; 10 straps enable it once host boot begins
   logic pll_en_reg;
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         pll_en_reg <= 1'b0;
      else if (!POWER_ON_RESET_N)
         pll_en_reg <= 1'b0;
      else if (SW_PLL_ENABLE)
         pll_en_reg <= 1'b1;
      else if (state_reg == RSB_ST_HOST && boot_reg == `RSB_BOOT_HOST_PLL)
         pll_en_reg <= 1'b1;
   assign PLL_ENABLE = pll_en_reg;
   assign PLL_BYPASS = ~pll_en_reg;

   // =====================================================
   // host boot word grouping
   rsb_word_pack u_pack
   (
      .CLK            (CLK),
      .RST            (RST),
      .clear          (state_reg != RSB_ST_HOST),
      .word_valid     (HOST_WORD_VALID & (state_reg == RSB_ST_HOST)),
      .word_in        (HOST_WORD),
      .group_reg      (HOST_GROUP),
      .group_valid_reg(HOST_GROUP_VALID)
   );

   // =====================================================
   // checks
   property p_capture;
      @(posedge CLK) disable iff (RST)
      capture |=> (boot_reg == $past(BOOT_SOURCE_STRAP)) &&
                  (wdog_reg == $past(WATCHDOG_ENABLE_STRAP));
   endproperty
   a_capture: assert property (p_capture) else $error("straps not captured");
   property p_hold;
      @(posedge CLK) disable iff (RST)
      !capture |=> $stable(width_reg) && $stable(pol_reg) && $stable(style_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("host straps changed");
   property p_i2c;
      @(posedge CLK) disable iff (RST)
      (state_reg == RSB_ST_ROM && boot_reg == `RSB_BOOT_I2C && !in_reset) |=> I2C_MASTER_MODE;
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c boot not entered");
   property p_host0;
      @(posedge CLK) disable iff (RST)
      (state_reg == RSB_ST_ROM && boot_reg == `RSB_BOOT_HOST_NOPLL && !in_reset)
         |=> HOST_BOOT_ACTIVE;
   endproperty
   a_host0: assert property (p_host0) else $error("host boot not entered");
   property p_pllon;
      @(posedge CLK) disable iff (RST)
      (HOST_BOOT_ACTIVE && boot_reg == `RSB_BOOT_HOST_PLL && POWER_ON_RESET_N) |=> PLL_ENABLE;
   endproperty
   a_pllon: assert property (p_pllon) else $error("pll not enabled");
   property p_bypass;
      @(posedge CLK) disable iff (RST)
      !POWER_ON_RESET_N |=> PLL_BYPASS;
   endproperty
   a_bypass: assert property (p_bypass) else $error("pll not bypassed");
   property p_rom;
      @(posedge CLK) disable iff (RST)
      (state_reg == RSB_ST_RESET && !in_reset) |=> ROM_BOOT_ACTIVE;
   endproperty
   a_rom: assert property (p_rom) else $error("rom stage skipped");
   property p_poll;
      @(posedge CLK) disable iff (RST)
      HOST_BOOT_ACTIVE |-> !HOST_DMA_ENABLE && !HOST_IRQ_ENABLE;
   endproperty
   a_poll: assert property (p_poll) else $error("host boot not polled");
   property p_wdog;
      @(posedge CLK) disable iff (RST)
      capture |=> WATCHDOG_ENABLE == $past(WATCHDOG_ENABLE_STRAP);
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog strap wrong");
   property p_capture_host;
      @(posedge CLK) disable iff (RST)
      capture |=> (pol_reg == $past(HOST_STROBE_POLARITY_STRAP)) &&
                  (style_reg == $past(HOST_STROBE_STYLE_STRAP)) &&
                  (width_reg == $past(HOST_BYTE_WIDTH_STRAP));
   endproperty
   a_capture_host: assert property (p_capture_host) else $error("host straps not captured");
   // rst counts as power-on, so the edge right after it may still capture
   property p_hard;
      @(posedge CLK) disable iff (RST)
      (!HARD_RESET_N && POWER_ON_RESET_N && $past(POWER_ON_RESET_N) && !$past(RST))
         |-> !capture;
   endproperty
   a_hard: assert property (p_hard) else $error("hard reset recaptured straps");
   property p_host_pll;
      @(posedge CLK) disable iff (RST)
      (state_reg == RSB_ST_ROM && boot_reg == `RSB_BOOT_HOST_PLL && !in_reset)
         |=> HOST_BOOT_ACTIVE;
   endproperty
   a_host_pll: assert property (p_host_pll) else $error("pll host boot not entered");
   property p_halt;
      @(posedge CLK) disable iff (RST)
      (state_reg == RSB_ST_ROM && BOOT_RESERVED && !in_reset)
         |=> !HOST_BOOT_ACTIVE && !I2C_PIN_SELECT;
   endproperty
   a_halt: assert property (p_halt) else $error("reserved code started a boot");
   property p_reserved;
      @(posedge CLK) disable iff (RST)
      BOOT_RESERVED |-> !HOST_BOOT_ACTIVE && !I2C_PIN_SELECT;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code booting");
   property p_no_pll;
      @(posedge CLK) disable iff (RST)
      (HOST_BOOT_ACTIVE && boot_reg == `RSB_BOOT_HOST_NOPLL && !PLL_ENABLE && !SW_PLL_ENABLE)
         |=> !PLL_ENABLE;
   endproperty
   a_no_pll: assert property (p_no_pll) else $error("pll enabled on code 00");
   property p_pll_sticky;
      @(posedge CLK) disable iff (RST)
      PLL_ENABLE && POWER_ON_RESET_N |=> PLL_ENABLE;
   endproperty
   a_pll_sticky: assert property (p_pll_sticky) else $error("pll dropped without reset");
   property p_swpll;
      @(posedge CLK) disable iff (RST)
      SW_PLL_ENABLE && POWER_ON_RESET_N |=> PLL_ENABLE;
   endproperty
   a_swpll: assert property (p_swpll) else $error("software pll enable ignored");
   property p_rom_once;
      @(posedge CLK) disable iff (RST)
      ROM_BOOT_ACTIVE |=> !ROM_BOOT_ACTIVE;
   endproperty
   a_rom_once: assert property (p_rom_once) else $error("rom stage stuck");
   property p_reset_state;
      @(posedge CLK) disable iff (RST)
      in_reset |=> !ROM_BOOT_ACTIVE && !HOST_BOOT_ACTIVE && !I2C_PIN_SELECT;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("boot ran during reset");
   property p_host_stay;
      @(posedge CLK) disable iff (RST)
      HOST_BOOT_ACTIVE && !in_reset |=> HOST_BOOT_ACTIVE;
   endproperty
   a_host_stay: assert property (p_host_stay) else $error("host boot left early");
   property p_i2c_stay;
      @(posedge CLK) disable iff (RST)
      I2C_PIN_SELECT && !in_reset |=> I2C_PIN_SELECT;
   endproperty
   a_i2c_stay: assert property (p_i2c_stay) else $error("i2c pins released early");
   property p_last_word;
      @(posedge CLK) disable iff (RST)
      HOST_GROUP_VALID |-> HOST_GROUP[15:0] == $past(HOST_WORD);
   endproperty
   a_last_word: assert property (p_last_word) else $error("last word not in low bits");
   property p_pulse;
      @(posedge CLK) disable iff (RST)
      HOST_GROUP_VALID |=> !HOST_GROUP_VALID;
   endproperty
   a_pulse: assert property (p_pulse) else $error("group valid held too long");
   c_host: cover property (@(posedge CLK) disable iff (RST) HOST_GROUP_VALID);
   c_i2c: cover property (@(posedge CLK) disable iff (RST) I2C_PIN_SELECT);
   c_halt: cover property (@(posedge CLK) disable iff (RST) state_reg == RSB_ST_HALT);
   c_pll: cover property (@(posedge CLK) disable iff (RST) PLL_ENABLE);
   c_hard: cover property (@(posedge CLK) disable iff (RST) !HARD_RESET_N && POWER_ON_RESET_N);
endmodule : rsb_boot_ctrl

// ===== rsb_host_model.sv
// external host model that writes boot words over the host port
`timescale 1ns/1ps
module rsb_host_model
(
   input  wire logic        clk,
   input  wire logic        start,
   input  wire logic [63:0] group,
   output logic             word_valid,
   output logic [15:0]      word
);
   // =========
   // writer
   // polled only: the model has no interrupt or dma request line
   initial
   begin
      word_valid = 1'b0;
      word = 16'h0;
      forever
      begin
         @(posedge clk iff start);
         for (int i = 3; i >= 0; i--)
         begin
            #1;
            word_valid = 1'b1;
            word = group[i*16 +: 16];
            @(posedge clk);
         end
         #1;
         word_valid = 1'b0;
         // released bus never shows the stale word
         word = ~word;
      end
   end
endmodule : rsb_host_model

// ===== rsb_map.svh
// constants for the reset strap and boot select block
`ifndef RSB_MAP_SVH
`define RSB_MAP_SVH
// boot source strap encodings
`define RSB_BOOT_HOST_NOPLL 2'h0
`define RSB_BOOT_I2C        2'h1
`define RSB_BOOT_HOST_PLL   2'h2
`define RSB_BOOT_RESERVED   2'h3
// host word and boot group
`define RSB_WORD_W          16
`define RSB_GROUP_WORDS     4
// reset values
`define RSB_RST_BOOT        2'h0
`define RSB_RST_FLAG        1'h0
`endif

// ===== rsb_pkg.sv
// types for the reset strap and boot select block
`include "rsb_map.svh"
package rsb_pkg;
   typedef enum logic [1:0] {RSB_SRC_HOST, RSB_SRC_I2C, RSB_SRC_NONE} rsb_src_t;
   typedef enum {RSB_ST_RESET, RSB_ST_ROM, RSB_ST_HOST, RSB_ST_I2C, RSB_ST_HALT} rsb_state_t;
endpackage : rsb_pkg

// ===== rsb_strap_latch.sv
// strap capture at power-on reset release
`timescale 1ns/1ps
module rsb_strap_latch
(
   input  wire logic       CLK,
   input  wire logic       RST,
   input  wire logic       por_active,
   input  wire logic [1:0] boot_in,
   input  wire logic       wdog_in,
   input  wire logic       pol_in,
   input  wire logic       style_in,
   input  wire logic       width_in,
   output logic      [1:0] boot_reg,
   output logic            wdog_reg,
   output logic            pol_reg,
   output logic            style_reg,
   output logic            width_reg,
   output logic            capture
);
   logic por_seen_reg;
   // capture on the clock edge where power-on reset drops; hard reset never reaches here
   assign capture = por_seen_reg & ~por_active;
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         por_seen_reg <= 1'b1;
      else
         por_seen_reg <= por_active;
   always_ff @(posedge CLK or posedge RST)
      if (RST)
      begin
         boot_reg  <= `RSB_RST_BOOT;
         wdog_reg  <= `RSB_RST_FLAG;
         pol_reg   <= `RSB_RST_FLAG;
         style_reg <= `RSB_RST_FLAG;
         width_reg <= `RSB_RST_FLAG;
      end
      else if (capture)
      begin
         boot_reg  <= boot_in;
         wdog_reg  <= wdog_in;
         pol_reg   <= pol_in;
         style_reg <= style_in;
         width_reg <= width_in;
      end
endmodule : rsb_strap_latch

// ===== rsb_word_pack.sv
// packs four host words, most significant first, into one group
`timescale 1ns/1ps
module rsb_word_pack
(
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        clear,
   input  wire logic        word_valid,
   input  wire logic [15:0] word_in,
   output logic      [63:0] group_reg,
   output logic             group_valid_reg
);
   logic [1:0] cnt_reg;
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         cnt_reg <= 2'h0;
      else if (clear)
         cnt_reg <= 2'h0;
      else if (word_valid)
         cnt_reg <= cnt_reg + 2'h1;
   // shift left so the first word ends up in the top bits; bit 0 stays the lsb
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         group_reg <= 64'h0;
      else if (word_valid)
         group_reg <= {group_reg[47:0], word_in};
   always_ff @(posedge CLK or posedge RST)
      if (RST)
         group_valid_reg <= 1'b0;
      else
         group_valid_reg <= word_valid & ~clear & (cnt_reg == 2'h3);
endmodule : rsb_word_pack

// ===== tb_top.sv
// self-checking bench for the reset strap and boot select block
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        por_n = 1'b0;
   logic        hard_n = 1'b1;
   logic [1:0]  boot = 2'h0;
   logic [3:0]  cfg = 4'h0;
   logic        sw_pll = 1'b0;
   logic        start = 1'b0;
   logic [63:0] grp = 64'h0123_4567_89ab_cdef;
   logic [63:0] grp_out;
   logic [15:0] wd;
   logic        wv, wdog, pol, sty, w8, pll, byp, rom, hb, dma, irq, gv, i2cp, i2cm, rsv;
   int          num_errors = 0;
   int          check_count = 0;

   always #20 clk = ~clk;

   rsb_boot_ctrl i_rsb_boot_ctrl
   (
      .CLK(clk), .RST(rst), .POWER_ON_RESET_N(por_n), .HARD_RESET_N(hard_n),
      .BOOT_SOURCE_STRAP(boot), .WATCHDOG_ENABLE_STRAP(cfg[3]),
      .HOST_STROBE_POLARITY_STRAP(cfg[2]), .HOST_STROBE_STYLE_STRAP(cfg[1]),
      .HOST_BYTE_WIDTH_STRAP(cfg[0]), .SW_PLL_ENABLE(sw_pll),
      .HOST_WORD_VALID(wv), .HOST_WORD(wd), .WATCHDOG_ENABLE(wdog),
      .HOST_STROBE_ACTIVE_HIGH(pol), .HOST_STROBE_STYLE(sty), .HOST_WIDTH_8BIT(w8),
      .PLL_ENABLE(pll), .PLL_BYPASS(byp), .ROM_BOOT_ACTIVE(rom), .HOST_BOOT_ACTIVE(hb),
      .HOST_DMA_ENABLE(dma), .HOST_IRQ_ENABLE(irq), .HOST_GROUP(grp_out),
      .HOST_GROUP_VALID(gv), .I2C_PIN_SELECT(i2cp), .I2C_MASTER_MODE(i2cm),
      .BOOT_RESERVED(rsv)
   );

   rsb_host_model i_rsb_host_model
   (
      .clk(clk), .start(start), .group(grp), .word_valid(wv), .word(wd)
   );

   // =========
   // helpers
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk_flag(string name, logic exp, logic got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %0b seen %0b", name, exp, got);
      end
   endtask : chk_flag

   task automatic chk_group(string name, logic [63:0] exp, logic [63:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_group

   task automatic chk_straps(logic [3:0] s);
      chk_flag("watchdog", s[3], wdog);
      chk_flag("polarity", s[2], pol);
      chk_flag("style", s[1], sty);
      chk_flag("width", s[0], w8);
   endtask : chk_straps

   task automatic wrap_up;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up

   // =========
   // scenarios
   task automatic boot_case(logic [1:0] code, logic [3:0] s);
      por_n = 1'b0;
      boot = code;
      cfg = s;
      tick(3);
      por_n = 1'b1;
      tick(1);
      chk_flag("rom", 1'b1, rom);
      chk_flag("bypass", 1'b1, byp);
      // straps move after release and must not leak through
      boot = ~code;
      cfg = ~s;
      tick(4);
      chk_straps(s);
      chk_flag("host", code[0] == 1'b0, hb);
      chk_flag("pll", code == 2'h2, pll);
      chk_flag("i2c pins", code == 2'h1, i2cp);
      chk_flag("i2c master", code == 2'h1, i2cm);
      chk_flag("reserved", code == 2'h3, rsv);
      chk_flag("dma", 1'b0, dma);
      chk_flag("irq", 1'b0, irq);
   endtask : boot_case

   task automatic hard_case;
      boot_case(2'h0, 4'ha);
      hard_n = 1'b0;
      tick(2);
      hard_n = 1'b1;
      tick(4);
      chk_straps(4'ha);
      chk_flag("host", 1'b1, hb);
   endtask : hard_case

   task automatic host_case;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      for (int i = 0; i < 10 && gv !== 1'b1; i++)
         tick(1);
      chk_flag("group valid", 1'b1, gv);
      chk_group("group", grp, grp_out);
      tick(1);
      chk_flag("group valid", 1'b0, gv);
   endtask : host_case

   task automatic pll_case;
      chk_flag("pll", 1'b0, pll);
      sw_pll = 1'b1;
      tick(1);
      sw_pll = 1'b0;
      tick(2);
      chk_flag("pll", 1'b1, pll);
      chk_flag("bypass", 1'b0, byp);
   endtask : pll_case

   // hang guard: all scenarios need well under 400 cycles
   initial
   begin
      repeat (2000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial
   begin
      tick(8);
      rst = 1'b0;
      for (int c = 0; c < 4; c++)
         boot_case(c[1:0], 4'h5 << c);
      hard_case();
      host_case();
      pll_case();
      boot_case(2'h0, 4'h3);
      wrap_up();
   end
endmodule : tb_top
